// *** rtra_cfg.svh ***
// Offsets, field positions, reset values and counts for the tick, round reset and alarm block.
// Assumes a 32-bit word-aligned register map with byte-wide registers.
`ifndef RTRA_CFG_SVH
`define RTRA_CFG_SVH

// Byte addresses of the register words
`define RTRA_OFF_CLOCK_CONTROL 32'h15700040
`define RTRA_OFF_TICK_COUNT_CONTROL 32'h15700044
`define RTRA_OFF_ALARM_CONTROL 32'h15700050
`define RTRA_OFF_ALARM_SECOND 32'h15700054
`define RTRA_OFF_ALARM_MINUTE 32'h15700058
`define RTRA_OFF_ALARM_HOUR 32'h1570005c
`define RTRA_OFF_ALARM_DAY 32'h15700060
`define RTRA_OFF_ROUND_RESET_CONTROL 32'h1570006c

// Reset values
`define RTRA_RST_CLOCK_CONTROL 8'h00
`define RTRA_RST_TICK_COUNT_CONTROL 8'h00
`define RTRA_RST_ALARM_CONTROL 8'h00
`define RTRA_RST_ALARM_SECOND 8'h00
`define RTRA_RST_ALARM_MINUTE 8'h00
`define RTRA_RST_ALARM_HOUR 8'h00
`define RTRA_RST_ALARM_DAY 8'h01
`define RTRA_RST_ROUND_RESET_CONTROL 8'h00

// Writable bit masks, reserved bits read as zero
`define RTRA_MSK_CLOCK_CONTROL 8'h0f
`define RTRA_MSK_ALARM_CONTROL 8'h7f
`define RTRA_MSK_ALARM_SECOND 8'h7f
`define RTRA_MSK_ALARM_MINUTE 8'h7f
`define RTRA_MSK_ALARM_HOUR 8'h3f
`define RTRA_MSK_ALARM_DAY 8'h3f
`define RTRA_MSK_ROUND_RESET_CONTROL 8'h0f

// Field positions
`define RTRA_CC_IFACE_EN 0
`define RTRA_CC_CLK_SEL 1
`define RTRA_CC_CHAIN_SEL 2
`define RTRA_CC_DIV_RST 3
`define RTRA_TICK_EN 7
`define RTRA_AC_GLOBAL_EN 6
`define RTRA_RR_ENABLE 3

// Crystal divider: 2^15 for seconds, 2^8 rising crystal edges per 1/128 s
`define RTRA_DIV_WIDTH 15
`define RTRA_DIV_SEC_LAST 15'h7fff
`define RTRA_DIV_TICK_LAST 8'hff

// BCD limits of the time counters
`define RTRA_SEC_LAST 8'h59
`define RTRA_MIN_LAST 8'h59
`define RTRA_HOUR_LAST 8'h23
`define RTRA_DAY_LAST 8'h31
`define RTRA_DAY_FIRST 8'h01
`define RTRA_ZERO_FIRST 8'h00

// Round boundaries in BCD seconds
`define RTRA_ROUND_30 8'h30
`define RTRA_ROUND_40 8'h40
`define RTRA_ROUND_50 8'h50

`endif

// *** rtra_pkg.sv ***
// Types shared by the tick, round reset and alarm block.
// Assumes rtra_cfg.svh supplies the numeric constants.
package rtra_pkg;
  typedef logic [7:0] rtra_byte_type;
  typedef logic [31:0] rtra_word_type;
  typedef logic [3:0] rtra_sel_type;
  typedef enum logic [2:0] {
    RTRA_BOUND_30 = 3'h3,
    RTRA_BOUND_40 = 3'h4,
    RTRA_BOUND_50 = 3'h5
  } rtra_bound_type;
endpackage

// *** rtra_tick_round_alarm.sv ***
// Tick interrupt, round second reset, control and alarm registers of a calendar clock.
// Assumes a classic Wishbone master on clk_i and a slow crystal square wave on xtal_i.
`timescale 1ns/1ps
`include "rtra_cfg.svh"

// What this block does
// RQ1: Tick period is (n+1)/128 seconds
// RQ2: Tick interrupt fires when count reaches zero
// RQ3: Tick register: enable bit 7, count 6:0
// RQ4: Reads return programmed count, not live count
// RQ5: Round reset forces seconds to zero
// RQ6: Seconds beyond boundary carry one into minutes; code carries only with merged counters (control bit 2 low)
// RQ7: Software uses single-byte accesses only
// RQ8: Control bit 0 low blocks writes, reads work; code keeps the control register itself writable
// RQ9: Software sets enable after reset, clears before off
// RQ10: Control bit 1 picks divided or raw crystal
// RQ11: Control bit 2 merges or separates counters
// RQ12: Control bit 3 holds divider in reset
// RQ13: Alarm control: global enable 6, field enables 5:0
// RQ14: Power-down alarm also drives wakeup output
// RQ15: Alarm second: tens 6:4, units 3:0
// RQ16: Alarm minute: tens 6:4, units 3:0
// RQ17: Alarm hour: tens 5:4, units 3:0
// RQ18: Alarm day: tens 5:4, units 3:0, reset 01
// RQ19: Byte lane lowest in little, highest in big endian
// RQ20: Boundary codes 011/100/101 are 30/40/50 seconds
// RQ21: Round reset register bit 3 enables round reset
// RQ22: Alarm when all enabled fields match time
// RQ23: Tick counter reloads at zero and continues
module rtra_tick_round_alarm (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire rtra_pkg::rtra_word_type adr_i,
  input wire rtra_pkg::rtra_sel_type sel_i,
  input wire rtra_pkg::rtra_word_type dat_i,
  output rtra_pkg::rtra_word_type dat_o,
  output logic ack_o,
  input wire logic xtal_i,
  input wire logic big_endian_i,
  input wire logic power_down_i,
  input wire logic [1:0] yr_mo_match_i,
  output logic tick_irq_o,
  output logic alarm_irq_o,
  output logic power_wakeup_out_o,
  output rtra_pkg::rtra_byte_type second_bcd_value_o,
  output rtra_pkg::rtra_byte_type minute_bcd_value_o,
  output rtra_pkg::rtra_byte_type hour_bcd_value_o,
  output rtra_pkg::rtra_byte_type day_bcd_value_o
);
  import rtra_pkg::*;

  // One BCD step: wraps from last to first, returns {wrap, next}
  function automatic logic [8:0] bcd_step(input rtra_byte_type v, input rtra_byte_type last,
                                          input rtra_byte_type first);
    logic [8:0] r;
    r = {1'b0, v + 8'h01};
    if (v == last) begin
      r = {1'b1, first};
    end else if (v[3:0] == 4'h9) begin
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    end
    return r;
  endfunction

  // Word address match, used for every register
  function automatic logic word_hit(input rtra_word_type a, input rtra_word_type off);
    return a[31:2] == off[31:2];
  endfunction

  // Seconds past the chosen boundary; every other code rounds with no carry
  // BCD seconds order the same way as binary, so a plain compare works
  function automatic logic round_over(input logic [2:0] code, input rtra_byte_type s);
    logic r;
    r = 1'b0;
    if (code == RTRA_BOUND_30) begin
      r = s > `RTRA_ROUND_30;
    end else if (code == RTRA_BOUND_40) begin
      r = s > `RTRA_ROUND_40;
    end else if (code == RTRA_BOUND_50) begin
      r = s > `RTRA_ROUND_50;
    end
    return r;
  endfunction

  rtra_byte_type clock_control_q;
  rtra_byte_type tick_count_control_q;
  rtra_byte_type alarm_control_q;
  rtra_byte_type alarm_second_q;
  rtra_byte_type alarm_minute_q;
  rtra_byte_type alarm_hour_q;
  rtra_byte_type alarm_day_q;
  rtra_byte_type round_reset_control_q;
  rtra_word_type dat_q;
  logic ack_q;
  logic xtal_meta_q;
  logic xtal_sync_q;
  logic xtal_prev_q;
  logic endian_meta_q;
  logic endian_sync_q;
  logic [`RTRA_DIV_WIDTH-1:0] div_q;
  logic [6:0] tick_cnt_q;
  logic tick_irq_q;
  rtra_byte_type sec_q;
  rtra_byte_type min_q;
  rtra_byte_type hour_q;
  rtra_byte_type day_q;
  logic time_moved_q;
  logic alarm_q;
  logic wakeup_q;

  // Bus request decode
  // An answered request is not taken twice; a held strobe acks every other cycle
  wire bus_req = cyc_i & stb_i & ~ack_q;
  wire hit_cc = word_hit(adr_i, `RTRA_OFF_CLOCK_CONTROL);
  wire hit_tc = word_hit(adr_i, `RTRA_OFF_TICK_COUNT_CONTROL);
  wire hit_ac = word_hit(adr_i, `RTRA_OFF_ALARM_CONTROL);
  wire hit_as = word_hit(adr_i, `RTRA_OFF_ALARM_SECOND);
  wire hit_am = word_hit(adr_i, `RTRA_OFF_ALARM_MINUTE);
  wire hit_ah = word_hit(adr_i, `RTRA_OFF_ALARM_HOUR);
  wire hit_ad = word_hit(adr_i, `RTRA_OFF_ALARM_DAY);
  wire hit_rr = word_hit(adr_i, `RTRA_OFF_ROUND_RESET_CONTROL);

  // Byte lane follows the endian pin: lane 0 little, lane 3 big
  wire lane_en = endian_sync_q ? sel_i[3] : sel_i[0]; // [RQ19]
  wire [7:0] wr_byte = endian_sync_q ? dat_i[31:24] : dat_i[7:0]; // [RQ19]
  wire iface_en = clock_control_q[`RTRA_CC_IFACE_EN];
  // Only the control register itself stays writable while the interface is off
  wire wr_ok = bus_req & we_i & lane_en & (iface_en | hit_cc); // [RQ8]
  wire wr_cc = wr_ok & hit_cc;
  wire wr_tc = wr_ok & hit_tc;
  wire wr_ac = wr_ok & hit_ac;
  wire wr_as = wr_ok & hit_as;
  wire wr_am = wr_ok & hit_am;
  wire wr_ah = wr_ok & hit_ah;
  wire wr_ad = wr_ok & hit_ad;
  wire wr_rr = wr_ok & hit_rr;

  // Read mux; tick register shows the programmed count, never the live one
  wire [7:0] rd_byte = ({8{hit_cc}} & clock_control_q)
                     | ({8{hit_tc}} & tick_count_control_q) // [RQ4]
                     | ({8{hit_ac}} & alarm_control_q)
                     | ({8{hit_as}} & alarm_second_q)
                     | ({8{hit_am}} & alarm_minute_q)
                     | ({8{hit_ah}} & alarm_hour_q)
                     | ({8{hit_ad}} & alarm_day_q)
                     | ({8{hit_rr}} & round_reset_control_q);
  // Unused lanes read zero so a wider load still sees one clean byte
  wire [31:0] rd_word = endian_sync_q ? {rd_byte, 24'h000000} : {24'h000000, rd_byte}; // [RQ19]

  // Crystal edge and divider pulses
  wire xtal_rise = xtal_sync_q & ~xtal_prev_q;
  wire div_hold = clock_control_q[`RTRA_CC_DIV_RST];
  wire tick_pulse = xtal_rise & ~div_hold & (div_q[7:0] == `RTRA_DIV_TICK_LAST);
  wire sec_div = xtal_rise & ~div_hold & (div_q == `RTRA_DIV_SEC_LAST);
  // Test setting counts on every rising crystal edge
  wire sec_pulse = clock_control_q[`RTRA_CC_CLK_SEL] ? xtal_rise : sec_div; // [RQ10]
  wire merged = ~clock_control_q[`RTRA_CC_CHAIN_SEL];

  // Round reset: a write with the enable bit set requests one round
  wire round_go = wr_rr & wr_byte[`RTRA_RR_ENABLE]; // [RQ21]
  wire [2:0] bound_code = wr_byte[2:0];
  wire beyond = round_over(bound_code, sec_q); // [RQ20]
  wire round_carry = round_go & beyond; // [RQ6]

  // Time counter chain
  wire [8:0] sec_nx = bcd_step(sec_q, `RTRA_SEC_LAST, `RTRA_ZERO_FIRST);
  wire [8:0] min_nx = bcd_step(min_q, `RTRA_MIN_LAST, `RTRA_ZERO_FIRST);
  wire [8:0] hour_nx = bcd_step(hour_q, `RTRA_HOUR_LAST, `RTRA_ZERO_FIRST);
  wire [8:0] day_nx = bcd_step(day_q, `RTRA_DAY_LAST, `RTRA_DAY_FIRST);
  // Separated counters all step on the count pulse for test
  wire min_adv = merged ? ((sec_pulse & sec_nx[8] & ~round_go) | round_carry) : sec_pulse; // [RQ11]
  wire hour_adv = merged ? (min_adv & min_nx[8]) : sec_pulse; // [RQ11]
  wire day_adv = merged ? (hour_adv & hour_nx[8]) : sec_pulse; // [RQ11]

  // Alarm compare, each field ignored unless its enable is set
  wire [5:0] field_ok;
  assign field_ok[0] = ~alarm_control_q[0] | (sec_q == alarm_second_q);
  assign field_ok[1] = ~alarm_control_q[1] | (min_q == alarm_minute_q);
  assign field_ok[2] = ~alarm_control_q[2] | (hour_q == alarm_hour_q);
  assign field_ok[3] = ~alarm_control_q[3] | (day_q == alarm_day_q);
  assign field_ok[4] = ~alarm_control_q[4] | yr_mo_match_i[0];
  assign field_ok[5] = ~alarm_control_q[5] | yr_mo_match_i[1];
  // Judged once per time change so a match raises one event, not a level
  wire alarm_hit = time_moved_q & alarm_control_q[`RTRA_AC_GLOBAL_EN] & (&field_ok); // [RQ22]

  // Wishbone answer: one wait state, ack drops the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= bus_req;
      dat_q <= bus_req ? rd_word : 32'h00000000;
    end
  end

  // Control and tick registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_control_q <= `RTRA_RST_CLOCK_CONTROL;
      tick_count_control_q <= `RTRA_RST_TICK_COUNT_CONTROL;
      round_reset_control_q <= `RTRA_RST_ROUND_RESET_CONTROL;
    end else begin
      if (wr_cc) begin
        clock_control_q <= wr_byte & `RTRA_MSK_CLOCK_CONTROL; // [RQ8] [RQ12]
      end
      if (wr_tc) begin
        tick_count_control_q <= wr_byte; // [RQ3]
      end
      if (wr_rr) begin
        round_reset_control_q <= wr_byte & `RTRA_MSK_ROUND_RESET_CONTROL; // [RQ21]
      end
    end
  end

  // Alarm registers, reserved bits forced to zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_control_q <= `RTRA_RST_ALARM_CONTROL;
      alarm_second_q <= `RTRA_RST_ALARM_SECOND;
      alarm_minute_q <= `RTRA_RST_ALARM_MINUTE;
      alarm_hour_q <= `RTRA_RST_ALARM_HOUR;
      alarm_day_q <= `RTRA_RST_ALARM_DAY; // [RQ18]
    end else begin
      if (wr_ac) begin
        alarm_control_q <= wr_byte & `RTRA_MSK_ALARM_CONTROL; // [RQ13]
      end
      if (wr_as) begin
        alarm_second_q <= wr_byte & `RTRA_MSK_ALARM_SECOND; // [RQ15]
      end
      if (wr_am) begin
        alarm_minute_q <= wr_byte & `RTRA_MSK_ALARM_MINUTE; // [RQ16]
      end
      if (wr_ah) begin
        alarm_hour_q <= wr_byte & `RTRA_MSK_ALARM_HOUR; // [RQ17]
      end
      if (wr_ad) begin
        alarm_day_q <= wr_byte & `RTRA_MSK_ALARM_DAY; // [RQ18]
      end
    end
  end

  // Pin synchronisers, two flops before any use
  // The previous-level flop reads only the second stage, never the first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xtal_meta_q <= 1'b0;
      xtal_sync_q <= 1'b0;
      xtal_prev_q <= 1'b0;
      endian_meta_q <= 1'b0;
      endian_sync_q <= 1'b0;
    end else begin
      xtal_meta_q <= xtal_i;
      xtal_sync_q <= xtal_meta_q;
      xtal_prev_q <= xtal_sync_q;
      endian_meta_q <= big_endian_i;
      endian_sync_q <= endian_meta_q;
    end
  end

  // Crystal divider, held at zero while its reset bit is set
  // With control bit 1 low, holding the divider freezes seconds at a known value for test
  always_ff @(posedge clk_i) begin
    if (rst_i || div_hold) begin
      div_q <= '0; // [RQ12]
    end else if (xtal_rise) begin
      div_q <= div_q + 15'h0001; // [RQ10]
    end
  end

  // Tick counter: n down to zero is n+1 ticks of 1/128 s
  // Disabling or rewriting reloads n; the divider runs on, so the first period can fall short of n+1 ticks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_q <= 7'h00;
      tick_irq_q <= 1'b0;
    end else begin
      tick_irq_q <= 1'b0;
      if (wr_tc || !tick_count_control_q[`RTRA_TICK_EN]) begin
        tick_cnt_q <= wr_tc ? wr_byte[6:0] : tick_count_control_q[6:0]; // [RQ3]
      end else if (tick_pulse) begin
        if (tick_cnt_q == 7'h00) begin
          tick_irq_q <= 1'b1; // [RQ2]
          tick_cnt_q <= tick_count_control_q[6:0]; // [RQ23] [RQ1]
        end else begin
          tick_cnt_q <= tick_cnt_q - 7'h01; // [RQ4] [RQ1]
        end
      end
    end
  end

  // Time counters; a round reset beats a same-cycle second step
  // With merged counters, round carry rides on the minute step, so hours and days follow it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sec_q <= `RTRA_ZERO_FIRST;
      min_q <= `RTRA_ZERO_FIRST;
      hour_q <= `RTRA_ZERO_FIRST;
      day_q <= `RTRA_DAY_FIRST;
      time_moved_q <= 1'b0;
    end else begin
      time_moved_q <= sec_pulse | round_go;
      if (round_go) begin
        sec_q <= `RTRA_ZERO_FIRST; // [RQ5]
      end else if (sec_pulse) begin
        sec_q <= sec_nx[7:0];
      end
      if (min_adv) begin
        min_q <= min_nx[7:0]; // [RQ6]
      end
      if (hour_adv) begin
        hour_q <= hour_nx[7:0];
      end
      if (day_adv) begin
        day_q <= day_nx[7:0];
      end
    end
  end

  // Alarm outputs; wakeup only while the system is powered down
  // Power state is taken at the same edge as the alarm, so both pulses line up
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_q <= 1'b0;
      wakeup_q <= 1'b0;
    end else begin
      alarm_q <= alarm_hit; // [RQ14]
      wakeup_q <= alarm_hit & power_down_i; // [RQ14]
    end
  end

  // Every output is a register, no logic between flop and port
  assign dat_o = dat_q;
  assign ack_o = ack_q;
  assign tick_irq_o = tick_irq_q;
  assign alarm_irq_o = alarm_q;
  assign power_wakeup_out_o = wakeup_q;
  assign second_bcd_value_o = sec_q;
  assign minute_bcd_value_o = min_q;
  assign hour_bcd_value_o = hour_q;
  assign day_bcd_value_o = day_q;
endmodule

// *** rtra_tick_round_alarm_asserts.sv ***
// Port checker for the tick, round reset and alarm block.
// Assumes one clock domain and a bind to every instance of the block.
`timescale 1ns/1ps
module rtra_tick_round_alarm_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire rtra_pkg::rtra_word_type dat_o,
  input wire logic ack_o,
  input wire logic power_down_i,
  input wire logic tick_irq_o,
  input wire logic alarm_irq_o,
  input wire logic power_wakeup_out_o,
  input wire rtra_pkg::rtra_byte_type second_bcd_value_o
);
  import rtra_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A taken request gets one ack, then ack drops
  sequence s_taken;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_answer;
    ack_o ##1 !ack_o;
  endsequence
  chk_ack_one_pulse: assert property (s_taken |=> s_answer)
    else $error("ack not a single answer");
  chk_ack_has_req: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  chk_dat_idle_zero: assert property (!ack_o |-> dat_o == 32'h00000000)
    else $error("read data outside ack");
  chk_lane_mid_zero: assert property (ack_o |-> dat_o[23:8] == 16'h0000)
    else $error("data outside byte lanes");
  chk_sec_bcd_legal: assert property (
    second_bcd_value_o[3:0] <= 4'h9 && second_bcd_value_o[7:4] <= 4'h5)
    else $error("seconds not legal bcd");
  chk_tick_single: assert property (tick_irq_o |=> !tick_irq_o)
    else $error("tick pulse too long");
  chk_alarm_single: assert property (alarm_irq_o |=> !alarm_irq_o)
    else $error("alarm pulse too long");
  chk_wake_needs_alarm: assert property (power_wakeup_out_o |-> alarm_irq_o)
    else $error("wakeup without alarm");
  // Power state held two cycles so the registered pulse sees a settled level
  chk_wake_in_down: assert property (
    alarm_irq_o && $past(power_down_i) && $past(power_down_i, 2) |-> power_wakeup_out_o)
    else $error("no wakeup in power down");
  chk_wake_not_normal: assert property (
    alarm_irq_o && !$past(power_down_i) && !$past(power_down_i, 2) |-> !power_wakeup_out_o)
    else $error("wakeup in normal mode");
endmodule

bind rtra_tick_round_alarm rtra_tick_round_alarm_asserts rtra_tick_round_alarm_asserts_inst (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
  .power_down_i(power_down_i), .tick_irq_o(tick_irq_o), .alarm_irq_o(alarm_irq_o),
  .power_wakeup_out_o(power_wakeup_out_o), .second_bcd_value_o(second_bcd_value_o));

// *** rtra_tick_round_alarm_tb_top.sv ***
// Self-checking bench for the tick, round reset and alarm block.
// Assumes a 50 ns clock and a bench-made crystal of XP clocks.
`timescale 1ns/1ps
module rtra_tick_round_alarm_tb_top;
  import rtra_pkg::*;
  localparam int XP = 8; // Fast crystal keeps the run short
  localparam rtra_word_type BASE = 32'h15700040;
  typedef struct {rtra_word_type a; rtra_byte_type r, w, e;} rtra_row_type;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, xtal_i = 1'b0;
  logic big_endian_i = 1'b0, power_down_i = 1'b0, ack_o, tick_irq_o, alarm_irq_o, wake_o;
  logic [1:0] yr_mo_match_i = 2'b00;
  rtra_word_type adr_i = 32'h0, dat_i = 32'h0, dat_o;
  rtra_sel_type sel_i = 4'h0;
  rtra_byte_type sec_o, min_o, hr_o, dy_o, m;
  int bad_count = 0, n_checks = 0, xc = 0, n;
  rtra_row_type rows[9] = '{'{BASE, 8'h00, 8'h01, 8'h01}, '{BASE + 4, 8'h00, 8'hff, 8'hff},
    '{BASE + 16, 8'h00, 8'hff, 8'h7f}, '{BASE + 20, 8'h00, 8'hff, 8'h7f},
    '{BASE + 24, 8'h00, 8'hff, 8'h7f}, '{BASE + 28, 8'h00, 8'hff, 8'h3f},
    '{BASE + 32, 8'h01, 8'hff, 8'h3f}, '{BASE + 44, 8'h00, 8'h07, 8'h07},
    '{BASE + 8, 8'h00, 8'hff, 8'h00}};
  rtra_byte_type codes[4] = '{8'h03, 8'h04, 8'h05, 8'h00};
  bit carry[4] = '{1'b1, 1'b1, 1'b0, 1'b0}; // Seconds sit near 45 when rounded
  rtra_tick_round_alarm rtra_tick_round_alarm_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .xtal_i, .big_endian_i, .power_down_i,
    .yr_mo_match_i, .tick_irq_o, .alarm_irq_o, .power_wakeup_out_o(wake_o),
    .second_bcd_value_o(sec_o), .minute_bcd_value_o(min_o), .hour_bcd_value_o(hr_o),
    .day_bcd_value_o(dy_o));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // Crystal locked to the clock so tick spacing is exact
  always @(posedge clk_i) begin
    xc <= (xc == XP - 1) ? 0 : xc + 1;
    xtal_i <= (xc < XP / 2);
  end
  task automatic check(input rtra_word_type seen, input rtra_word_type exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle; lane follows the endian pin
  task automatic wb(input logic w, input rtra_word_type a, input rtra_byte_type d,
                    output rtra_byte_type q);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= big_endian_i ? a + 32'h3 : a;
    sel_i <= big_endian_i ? 4'h8 : 4'h1;
    dat_i <= big_endian_i ? {d, 24'h0} : {24'h0, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    if (k >= 20) check(32'h1, 32'h0);
    q = big_endian_i ? dat_o[31:24] : dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic wr(input rtra_word_type a, input rtra_byte_type d);
    rtra_byte_type q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rdc(input rtra_word_type a, input rtra_byte_type e);
    rtra_byte_type q;
    wb(1'b0, a, 8'h00, q);
    check({24'h0, q}, {24'h0, e});
  endtask
  // Mode 0 tick, 1 alarm, 2 seconds equal s; bounded wait
  task automatic wait_evt(input int md, input rtra_byte_type s, output int c);
    c = 0;
    do begin
      @(posedge clk_i);
      c++;
    end while (!(md == 0 ? tick_irq_o === 1'b1 : md == 1 ? alarm_irq_o === 1'b1 : sec_o === s)
               && c < 20000);
    if (c >= 20000) check(32'h1, 32'h0);
  endtask
  task automatic end_sim;
    if (bad_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #(60000 * 50);
    bad_count++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      rdc(rows[i].a, rows[i].r);
      wr(rows[i].a, rows[i].w);
      rdc(rows[i].a, rows[i].e);
    end
    wr(BASE, 8'h00);
    wr(BASE + 20, 8'h12);
    rdc(BASE + 20, 8'h7f);
    wr(BASE, 8'h01);
    big_endian_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    wr(BASE + 24, 8'h34);
    rdc(BASE + 24, 8'h34);
    big_endian_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rdc(BASE + 24, 8'h34);
    wr(BASE + 4, 8'h83);
    wait_evt(0, 8'h00, n);
    wait_evt(0, 8'h00, n);
    check(rtra_word_type'(n), 4 * 256 * XP);
    // One tick later the live count is 2; the read must still show the programmed 3
    repeat (2100) @(posedge clk_i);
    rdc(BASE + 4, 8'h83);
    wr(BASE + 4, 8'h03);
    n = 0;
    repeat (9000) begin
      @(posedge clk_i);
      n += (tick_irq_o === 1'b1);
    end
    check(rtra_word_type'(n), 32'h0);
    rdc(BASE + 4, 8'h03);
    // Raw crystal counts seconds fast; divider reset then freezes them
    m = 8'h00;
    foreach (codes[i]) begin
      wr(BASE, 8'h03);
      wait_evt(2, 8'h45, n);
      wr(BASE, 8'h09);
      wr(BASE + 44, codes[i]);
      check({31'h0, sec_o === 8'h00}, 32'h0);
      wr(BASE + 44, 8'h08 | codes[i]);
      m = m + carry[i];
      check({16'h0, sec_o, min_o}, {16'h0, 8'h00, m});
    end
    wr(BASE + 20, 8'h05);
    wr(BASE + 16, 8'h41);
    wr(BASE, 8'h03);
    for (int p = 0; p < 2; p++) begin
      power_down_i <= p[0];
      wait_evt(1, 8'h00, n);
      check({16'h0, sec_o, 7'h0, wake_o}, {16'h0, 8'h05, 7'h0, p[0]});
    end
    wr(BASE + 16, 8'h01);
    n = 0;
    repeat (600) begin
      @(posedge clk_i);
      n += (alarm_irq_o === 1'b1);
    end
    check(rtra_word_type'(n), 32'h0);
    // Mid-run reset brings back the start time and the reset values
    power_down_i <= 1'b0;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    check({sec_o, min_o, hr_o, dy_o}, {8'h00, 8'h00, 8'h00, 8'h01});
    rdc(BASE, 8'h00);
    rdc(BASE + 32, 8'h01);
    rdc(BASE + 16, 8'h00);
    // Separated counters all step on each raw crystal rise
    wr(BASE, 8'h07);
    wait_evt(2, 8'h03, n);
    check({8'h00, min_o, hr_o, dy_o}, {8'h00, 8'h03, 8'h03, 8'h04});
    wr(BASE, 8'h00);
    end_sim();
  end
endmodule
